// File: logic/sdm_regs.svh
// Behaviour
// - Requests arrive on identifier 0x600 plus node; answers leave on 0x580 plus node.
// - Read 0x40 with index and subindex; reply 0x43 echoes them, value LSB first.
// - One-byte write 0x2B carries value in byte 4; acknowledge 0x60 echoes address.
// - Fourteen independent 32-bit unsigned data memories.
// - Answer only after processing ends; error on bad address, link fault, damage.
// - Set-to-constant write only while unlocked; one set per unlock.
// - Increment writes accepted at any time, whatever the lock state.
// - Increment overflow stores all ones, without error.
// - Measurement held while sensor memories are accessed.
// - Sensor accessed on every accepted memory write; read after power-on, replacement, wire break.
// - Repeated reads served from the cached value, no sensor access.
// - Object 0x3590 sub 0x00 is read-only and returns memory count.
// - 0x3590 sub 0x01..0x0E: write adds increment, read returns value.
// - Key 0x6B636C75 to 0x359F sub 0x01 unlocks; other values abort and lock.
// - Write 0x3591 sub 1..14 stores value directly, then relocks.
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

// Frame identifiers
`define SDM_ID_RX_BASE 11'h600
`define SDM_ID_TX_BASE 11'h580

// Command bytes
`define SDM_CMD_RD 8'h40
`define SDM_CMD_RD_ACK 8'h43
`define SDM_CMD_WR1 8'h2b
`define SDM_CMD_WR4 8'h23
`define SDM_CMD_WR_ACK 8'h60
`define SDM_CMD_ABORT 8'h80

// Object map
`define SDM_IDX_INC 16'h3590
`define SDM_IDX_SET 16'h3591
`define SDM_IDX_KEY 16'h359f
`define SDM_SUB_COUNT 8'h00
`define SDM_SUB_KEY 8'h01
`define SDM_SUB_FIRST 8'h01
`define SDM_SUB_LAST 8'h0e
`define SDM_UNLOCK_KEY 32'h6b636c75
`define SDM_MEM_NUM 14
`define SDM_MEM_COUNT 32'h0000000e
`define SDM_SAT_VALUE 32'hffffffff

// Abort codes
`define SDM_AB_CMD 32'h05040001
`define SDM_AB_TIMEOUT 32'h05040000
`define SDM_AB_RD_WO 32'h06010001
`define SDM_AB_WR_RO 32'h06010002
`define SDM_AB_NO_OBJ 32'h06020000
`define SDM_AB_NO_SUB 32'h06090011
`define SDM_AB_HW 32'h06060000
`define SDM_AB_LOCKED 32'h08000022
`define SDM_AB_KEY 32'h08000020

// Frame bit positions
`define SDM_POS_CMD 0
`define SDM_POS_IDX 8
`define SDM_POS_SUB 24
`define SDM_POS_VAL 32

// Timing
`define SDM_CLK_KHZ 50000
`define SDM_TMO_MS 3000

`endif

// File: logic/sdm_pkg.sv
package sdm_pkg;

   // Request decoder states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SNS   = 3'b010,
      ST_REPLY = 3'b100
   } sdm_state_t;

   // What a pending sensor access is for
   typedef enum logic [1:0] {
      OP_RD  = 2'h0,
      OP_INC = 2'h1,
      OP_WR  = 2'h2
   } sdm_op_t;

   // One sensor memory access
   typedef struct packed {
      logic start;
      logic wr;
      logic [3:0] sel;
      logic [31:0] wdata;
   } sdm_sns_req_t;

   // Completion of a sensor memory access
   typedef struct packed {
      logic done;
      logic err;
      logic [31:0] rdata;
   } sdm_sns_rsp_t;

   // Outgoing CAN frame
   typedef struct packed {
      logic valid;
      logic [10:0] id;
      logic [63:0] data;
   } sdm_frame_t;

endpackage

// File: logic/sdm_sens_port.sv
`timescale 1ns/100ps
`include "sdm_regs.svh"

module sdm_sens_port #(
   parameter int unsigned TMO_CYC = `SDM_TMO_MS * `SDM_CLK_KHZ
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire sdm_pkg::sdm_sns_req_t i_req,
   output sdm_pkg::sdm_sns_rsp_t o_rsp,
   output logic o_sns_req,
   output logic o_sns_wr,
   output logic [3:0] o_sns_sel,
   output logic [31:0] o_sns_wdata,
   input wire logic i_sns_done,
   input wire logic i_sns_err,
   input wire logic [31:0] i_sns_rdata
);

   typedef struct packed {
      logic req;
      logic wr;
      logic [3:0] sel;
      logic [31:0] wdata;
      logic [31:0] cnt;
      sdm_pkg::sdm_sns_rsp_t rsp;
   } sdm_port_st_t;

   sdm_port_st_t r;
   sdm_port_st_t next_r;

   // Access sequencing with a watchdog on the sensor answer
   always_comb begin
      next_r = r;
      next_r.rsp.done = 1'b0;
      if (!r.req) begin
         if (i_req.start) begin
            next_r.req = 1'b1;
            next_r.wr = i_req.wr;
            next_r.sel = i_req.sel;
            next_r.wdata = i_req.wdata;
            next_r.cnt = 32'h0;
         end
      end else if (i_sns_done) begin
         next_r.req = 1'b0;
         next_r.rsp.done = 1'b1;
         next_r.rsp.err = i_sns_err;
         next_r.rsp.rdata = i_sns_rdata;
      end else if (r.cnt == TMO_CYC - 1) begin
         next_r.req = 1'b0;
         next_r.rsp.done = 1'b1;
         next_r.rsp.err = 1'b1;
      end else begin
         next_r.cnt = r.cnt + 32'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_rsp = r.rsp;
   assign o_sns_req = r.req;
   assign o_sns_wr = r.wr;
   assign o_sns_sel = r.sel;
   assign o_sns_wdata = r.wdata;

endmodule

// File: logic/sdm_top.sv
`timescale 1ns/100ps
`include "sdm_regs.svh"

module sdm_top #(
   parameter int unsigned TMO_CYC = `SDM_TMO_MS * `SDM_CLK_KHZ
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [6:0] I_NODE_ID,
   input wire logic I_RX_VALID,
   input wire logic [10:0] I_RX_ID,
   input wire logic [63:0] I_RX_DATA,
   output logic O_RX_READY,
   output logic O_TX_VALID,
   output logic [10:0] O_TX_ID,
   output logic [63:0] O_TX_DATA,
   input wire logic I_TX_READY,
   output logic O_SNS_REQ,
   output logic O_SNS_WR,
   output logic [3:0] O_SNS_SEL,
   output logic [31:0] O_SNS_WDATA,
   input wire logic I_SNS_DONE,
   input wire logic I_SNS_ERR,
   input wire logic [31:0] I_SNS_RDATA,
   input wire logic I_SNS_EVENT,
   output logic O_MEAS_HOLD
);

   // ********************************************************
   // State
   // ********************************************************

   typedef struct packed {
      sdm_pkg::sdm_state_t state;
      sdm_pkg::sdm_op_t op;
      logic rx_ready;
      logic locked;
      logic [15:0] idx;
      logic [7:0] sub;
      logic [31:0] val;
      logic [`SDM_MEM_NUM-1:0] cvalid;
      logic [`SDM_MEM_NUM-1:0][31:0] cache;
      sdm_pkg::sdm_sns_req_t sreq;
      sdm_pkg::sdm_frame_t tx;
   } sdm_st_t;

   sdm_st_t r;
   sdm_st_t next_r;
   sdm_pkg::sdm_sns_rsp_t srsp;

   // ********************************************************
   // Helpers
   // ********************************************************

   // Subindex names one of the data memories
   function automatic logic mem_hit(input logic [7:0] sub);
      mem_hit = (sub >= `SDM_SUB_FIRST) && (sub <= `SDM_SUB_LAST);
   endfunction

   // Memory number from subindex
   function automatic logic [3:0] mem_sel(input logic [7:0] sub);
      logic [7:0] d;
      d = sub - `SDM_SUB_FIRST;
      mem_sel = d[3:0];
   endfunction

   // Build an answer frame, value least significant byte first
   function automatic logic [63:0] frame(input logic [7:0] cmd,
      input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] val);
      frame = {val, sub, idx, cmd};
   endfunction

   // Add an increment, sticking at the top of the range
   function automatic logic [31:0] sat_add(input logic [31:0] a,
      input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[32] ? `SDM_SAT_VALUE : s[31:0];
   endfunction

   // ********************************************************
   // Sensor access
   // ********************************************************

   sdm_sens_port #(
      .TMO_CYC(TMO_CYC)
   ) u_port (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_req(r.sreq),
      .o_rsp(srsp),
      .o_sns_req(O_SNS_REQ),
      .o_sns_wr(O_SNS_WR),
      .o_sns_sel(O_SNS_SEL),
      .o_sns_wdata(O_SNS_WDATA),
      .i_sns_done(I_SNS_DONE),
      .i_sns_err(I_SNS_ERR),
      .i_sns_rdata(I_SNS_RDATA)
   );

   // ********************************************************
   // Request decoder
   // ********************************************************

   logic [10:0] rx_id;
   logic [10:0] tx_id;
   logic [7:0] cmd;
   logic [15:0] idx;
   logic [7:0] sub;
   logic [31:0] val;
   logic [3:0] sel;
   logic is_wr;

   // Request fields
   always_comb begin
      rx_id = `SDM_ID_RX_BASE + {4'h0, I_NODE_ID};
      tx_id = `SDM_ID_TX_BASE + {4'h0, I_NODE_ID};
      cmd = I_RX_DATA[`SDM_POS_CMD +: 8];
      idx = I_RX_DATA[`SDM_POS_IDX +: 16];
      sub = I_RX_DATA[`SDM_POS_SUB +: 8];
      is_wr = (cmd == `SDM_CMD_WR1) || (cmd == `SDM_CMD_WR4);
      if (cmd == `SDM_CMD_WR1) begin
         val = {24'h0, I_RX_DATA[`SDM_POS_VAL +: 8]};
      end else begin
         val = I_RX_DATA[`SDM_POS_VAL +: 32];
      end
      sel = mem_sel(sub);
   end

   // Next state of the whole block
   always_comb begin
      next_r = r;
      next_r.sreq.start = 1'b0;
      // Sensor swapped or lead broken: cached values are stale
      if (I_SNS_EVENT) begin
         next_r.cvalid = '0;
      end
      unique case (r.state)
         sdm_pkg::ST_IDLE: begin
            if (I_RX_VALID && r.rx_ready && I_RX_ID == rx_id) begin
               next_r.rx_ready = 1'b0;
               next_r.idx = idx;
               next_r.sub = sub;
               next_r.val = val;
               next_r.tx.valid = 1'b1;
               next_r.tx.id = tx_id;
               next_r.state = sdm_pkg::ST_REPLY;
               next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                  `SDM_AB_CMD);
               if (cmd == `SDM_CMD_RD) begin
                  if (idx == `SDM_IDX_INC && sub == `SDM_SUB_COUNT) begin
                     next_r.tx.data = frame(`SDM_CMD_RD_ACK, idx, sub,
                        `SDM_MEM_COUNT);
                  end else if ((idx == `SDM_IDX_INC ||
                        idx == `SDM_IDX_SET) && mem_hit(sub)) begin
                     if (r.cvalid[sel]) begin
                        next_r.tx.data = frame(`SDM_CMD_RD_ACK, idx, sub,
                           r.cache[sel]);
                     end else begin
                        // First read since power-on or sensor change
                        next_r.tx.valid = 1'b0;
                        next_r.op = sdm_pkg::OP_RD;
                        next_r.sreq = '{1'b1, 1'b0, sel, 32'h0};
                        next_r.state = sdm_pkg::ST_SNS;
                     end
                  end else if (idx == `SDM_IDX_KEY &&
                        sub == `SDM_SUB_KEY) begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_RD_WO);
                  end else if (idx == `SDM_IDX_INC || idx == `SDM_IDX_SET
                        || idx == `SDM_IDX_KEY) begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_NO_SUB);
                  end else begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_NO_OBJ);
                  end
               end else if (is_wr) begin
                  if (idx == `SDM_IDX_INC && sub == `SDM_SUB_COUNT) begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_WR_RO);
                  end else if (idx == `SDM_IDX_INC && mem_hit(sub)) begin
                     // Increments ignore the lock
                     next_r.tx.valid = 1'b0;
                     next_r.state = sdm_pkg::ST_SNS;
                     if (r.cvalid[sel]) begin
                        next_r.op = sdm_pkg::OP_WR;
                        next_r.val = sat_add(r.cache[sel], val);
                        next_r.sreq = '{1'b1, 1'b1, sel,
                           sat_add(r.cache[sel], val)};
                     end else begin
                        next_r.op = sdm_pkg::OP_INC;
                        next_r.sreq = '{1'b1, 1'b0, sel, 32'h0};
                     end
                  end else if (idx == `SDM_IDX_SET && mem_hit(sub)) begin
                     if (r.locked) begin
                        next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                           `SDM_AB_LOCKED);
                     end else begin
                        next_r.locked = 1'b1;
                        next_r.tx.valid = 1'b0;
                        next_r.op = sdm_pkg::OP_WR;
                        next_r.sreq = '{1'b1, 1'b1, sel, val};
                        next_r.state = sdm_pkg::ST_SNS;
                     end
                  end else if (idx == `SDM_IDX_KEY &&
                        sub == `SDM_SUB_KEY) begin
                     if (val == `SDM_UNLOCK_KEY) begin
                        next_r.locked = 1'b0;
                        next_r.tx.data = frame(`SDM_CMD_WR_ACK, idx, sub,
                           32'h0);
                     end else begin
                        next_r.locked = 1'b1;
                        next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                           `SDM_AB_KEY);
                     end
                  end else if (idx == `SDM_IDX_INC || idx == `SDM_IDX_SET
                        || idx == `SDM_IDX_KEY) begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_NO_SUB);
                  end else begin
                     next_r.tx.data = frame(`SDM_CMD_ABORT, idx, sub,
                        `SDM_AB_NO_OBJ);
                  end
               end
            end
         end
         sdm_pkg::ST_SNS: begin
            // Answer held back until the sensor access is over
            if (srsp.done) begin
               next_r.tx.valid = 1'b1;
               next_r.state = sdm_pkg::ST_REPLY;
               if (srsp.err) begin
                  next_r.cvalid[mem_sel(r.sub)] = 1'b0;
                  next_r.tx.data = frame(`SDM_CMD_ABORT, r.idx, r.sub,
                     `SDM_AB_HW);
               end else begin
                  unique case (r.op)
                     sdm_pkg::OP_RD: begin
                        next_r.cache[mem_sel(r.sub)] = srsp.rdata;
                        next_r.cvalid[mem_sel(r.sub)] = 1'b1;
                        next_r.tx.data = frame(`SDM_CMD_RD_ACK, r.idx,
                           r.sub, srsp.rdata);
                     end
                     sdm_pkg::OP_INC: begin
                        // Value fetched, now write the sum back
                        next_r.tx.valid = 1'b0;
                        next_r.state = sdm_pkg::ST_SNS;
                        next_r.op = sdm_pkg::OP_WR;
                        next_r.val = sat_add(srsp.rdata, r.val);
                        next_r.sreq = '{1'b1, 1'b1, mem_sel(r.sub),
                           sat_add(srsp.rdata, r.val)};
                     end
                     default: begin
                        next_r.cache[mem_sel(r.sub)] = r.val;
                        next_r.cvalid[mem_sel(r.sub)] = 1'b1;
                        next_r.tx.data = frame(`SDM_CMD_WR_ACK, r.idx,
                           r.sub, 32'h0);
                     end
                  endcase
               end
            end
         end
         sdm_pkg::ST_REPLY: begin
            if (I_TX_READY) begin
               next_r.tx.valid = 1'b0;
               next_r.rx_ready = 1'b1;
               next_r.state = sdm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_r.state = sdm_pkg::ST_IDLE;
            next_r.rx_ready = 1'b1;
            next_r.tx.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         r <= '0;
         r.state <= sdm_pkg::ST_IDLE;
         r.rx_ready <= 1'b1;
         r.locked <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************

   assign O_RX_READY = r.rx_ready;
   assign O_TX_VALID = r.tx.valid;
   assign O_TX_ID = r.tx.id;
   assign O_TX_DATA = r.tx.data;
   assign O_MEAS_HOLD = O_SNS_REQ;

endmodule

// File: dv/sdm_top_sva.sv
`timescale 1ns/100ps
// ****************************************
// Answer server port checker
// ****************************************
module sdm_top_sva #(
   parameter int unsigned TMO_CYC = 150000000
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [6:0] I_NODE_ID,
   input wire logic I_RX_VALID,
   input wire logic [10:0] I_RX_ID,
   input wire logic [63:0] I_RX_DATA,
   input wire logic O_RX_READY,
   input wire logic O_TX_VALID,
   input wire logic [10:0] O_TX_ID,
   input wire logic [63:0] O_TX_DATA,
   input wire logic I_TX_READY,
   input wire logic O_SNS_REQ,
   input wire logic O_SNS_WR,
   input wire logic [3:0] O_SNS_SEL,
   input wire logic I_SNS_DONE,
   input wire logic I_SNS_ERR,
   input wire logic O_MEAS_HOLD
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   // Consecutive cycles of a pending sensor access
   int unsigned req_cyc;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !O_SNS_REQ) begin
         req_cyc <= 0;
      end else begin
         req_cyc <= req_cyc + 1;
      end
   end

   // Request steps
   sequence s_take;
      I_RX_VALID && O_RX_READY && I_RX_ID == 11'h600 + {4'h0, I_NODE_ID};
   endsequence
   sequence s_inc_wr;
      (I_RX_DATA[7:0] == 8'h2b || I_RX_DATA[7:0] == 8'h23) &&
      I_RX_DATA[23:8] == 16'h3590 && I_RX_DATA[31:24] inside {[1:14]};
   endsequence
   sequence s_fail;
      O_SNS_REQ && I_SNS_DONE && I_SNS_ERR;
   endsequence

   property p_tx_id;
      O_TX_VALID |-> O_TX_ID == 11'h580 + {4'h0, I_NODE_ID};
   endproperty
   property p_cmd;
      O_TX_VALID |-> O_TX_DATA[7:0] inside {8'h43, 8'h60, 8'h80};
   endproperty
   property p_tx_stand;
      O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA);
   endproperty
   property p_one;
      O_TX_VALID || O_SNS_REQ |-> !O_RX_READY;
   endproperty
   property p_hold;
      O_SNS_REQ |-> O_MEAS_HOLD;
   endproperty
   property p_sns_stand;
      O_SNS_REQ && $past(O_SNS_REQ) |-> $stable(O_SNS_SEL) && $stable(O_SNS_WR);
   endproperty
   property p_wr_start;
      s_take ##0 s_inc_wr |-> ##2 O_SNS_REQ [*2];
   endproperty
   property p_fail;
      s_fail |-> ##2 O_TX_VALID && O_TX_DATA[7:0] == 8'h80 &&
         O_TX_DATA[63:32] == 32'h06060000;
   endproperty
   property p_count;
      s_take ##0 I_RX_DATA[31:0] == 32'h00359040 |=>
         O_TX_VALID && O_TX_DATA == 64'h0000000e_00359043;
   endproperty
   property p_tmo;
      req_cyc <= TMO_CYC + 1;
   endproperty

   a_tx_id: assert property (p_tx_id) else $error("bad answer id");
   a_cmd: assert property (p_cmd) else $error("bad answer cmd");
   a_tx_stand: assert property (p_tx_stand) else $error("answer moved");
   a_one: assert property (p_one) else $error("second request taken");
   a_hold: assert property (p_hold) else $error("no measure hold");
   a_sns_stand: assert property (p_sns_stand) else $error("access moved");
   a_wr_start: assert property (p_wr_start) else $error("write no access");
   a_fail: assert property (p_fail) else $error("fault not aborted");
   a_count: assert property (p_count) else $error("bad memory count");
   a_tmo: assert property (p_tmo) else $error("access too long");
endmodule

bind sdm_top sdm_top_sva #(.TMO_CYC(TMO_CYC)) sdm_top_sva_inst (
   .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_NODE_ID(I_NODE_ID),
   .I_RX_VALID(I_RX_VALID), .I_RX_ID(I_RX_ID), .I_RX_DATA(I_RX_DATA),
   .O_RX_READY(O_RX_READY), .O_TX_VALID(O_TX_VALID), .O_TX_ID(O_TX_ID),
   .O_TX_DATA(O_TX_DATA), .I_TX_READY(I_TX_READY), .O_SNS_REQ(O_SNS_REQ),
   .O_SNS_WR(O_SNS_WR), .O_SNS_SEL(O_SNS_SEL), .I_SNS_DONE(I_SNS_DONE),
   .I_SNS_ERR(I_SNS_ERR), .O_MEAS_HOLD(O_MEAS_HOLD)
);

// File: dv/sdm_sens_model.sv
`timescale 1ns/100ps
// ****************************************
// Sensor with fourteen counter memories
// ****************************************
module sdm_sens_model (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [3:0] i_sel,
   input wire logic [31:0] i_wdata,
   input wire logic i_fail,
   input wire logic i_mute,
   input wire logic i_slow,
   output logic o_done,
   output logic o_err,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [14];
   int cnt;

   // Preset contents, last one near the top of the range
   initial begin
      for (int k = 0; k < 14; k++) begin
         mem[k] = 32'h00000100 + k;
      end
      mem[13] = 32'hfffffff0;
      cnt = 0;
      o_done = 1'b0;
      o_err = 1'b0;
      o_rdata = 32'h0;
   end

   // Answer after a short or long delay, or never when muted
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!i_req) begin
         cnt <= 0;
      end else if (cnt == (i_slow ? 40 : 2) && !i_mute) begin
         o_done <= 1'b1;
         o_err <= i_fail;
         o_rdata <= mem[i_sel];
         cnt <= cnt + 1;
         if (i_wr && !i_fail) begin
            mem[i_sel] <= i_wdata;
         end
      end else if (cnt < (i_slow ? 40 : 2)) begin
         cnt <= cnt + 1;
      end
   end
endmodule

// File: dv/test_sdo_sensor_data_memory.sv
`timescale 1ns/100ps
// ****************************************
// Bench for the data memory server
// ****************************************
module test_sdo_sensor_data_memory;
   typedef struct {
      logic [7:0] cmd;
      logic [15:0] idx;
      logic [7:0] sub;
      logic [31:0] val;
      logic [7:0] ecmd;
      logic [31:0] eval;
   } sdm_row_t;
   logic clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, ev, req_q;
   logic sns_req, sns_wr, sns_done, sns_err, hold, fail, mute, slow;
   logic [10:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data;
   logic [3:0] sns_sel;
   logic [31:0] sns_wdata, sns_rdata;
   int mismatches = 0;
   int total_checks = 0;
   int rises = 0;
   int hold_bad = 0;

   // Requests with the answer each must give
   sdm_row_t rows [16] = '{
      '{8'h40, 16'h3590, 8'h00, 32'h0, 8'h43, 32'he},
      '{8'h40, 16'h3590, 8'h01, 32'h0, 8'h43, 32'h100},
      '{8'h2b, 16'h3590, 8'h01, 32'h5, 8'h60, 32'h0},
      '{8'h40, 16'h3590, 8'h01, 32'h0, 8'h43, 32'h105},
      '{8'h23, 16'h3590, 8'h0e, 32'h20, 8'h60, 32'h0},
      '{8'h40, 16'h3590, 8'h0e, 32'h0, 8'h43, 32'hffffffff},
      '{8'h2b, 16'h3590, 8'h00, 32'h1, 8'h80, 32'h06010002},
      '{8'h40, 16'h3590, 8'h0f, 32'h0, 8'h80, 32'h06090011},
      '{8'h40, 16'h3592, 8'h01, 32'h0, 8'h80, 32'h06020000},
      '{8'h23, 16'h3591, 8'h01, 32'h7, 8'h80, 32'h08000022},
      '{8'h23, 16'h359f, 8'h01, 32'h6b636c75, 8'h60, 32'h0},
      '{8'h23, 16'h3591, 8'h01, 32'h7, 8'h60, 32'h0},
      '{8'h23, 16'h3591, 8'h01, 32'h8, 8'h80, 32'h08000022},
      '{8'h23, 16'h359f, 8'h01, 32'h1, 8'h80, 32'h08000020},
      '{8'h40, 16'h3590, 8'h01, 32'h0, 8'h43, 32'h7},
      '{8'h55, 16'h3590, 8'h01, 32'h0, 8'h80, 32'h05040001}
   };

   sdm_top #(.TMO_CYC(200)) sdm_top_inst (
      .I_CLK_SYS(clk), .I_RST(rst), .I_NODE_ID(7'h03),
      .I_RX_VALID(rx_valid), .I_RX_ID(rx_id), .I_RX_DATA(rx_data),
      .O_RX_READY(rx_ready), .O_TX_VALID(tx_valid), .O_TX_ID(tx_id),
      .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .O_SNS_REQ(sns_req),
      .O_SNS_WR(sns_wr), .O_SNS_SEL(sns_sel), .O_SNS_WDATA(sns_wdata),
      .I_SNS_DONE(sns_done), .I_SNS_ERR(sns_err), .I_SNS_RDATA(sns_rdata),
      .I_SNS_EVENT(ev), .O_MEAS_HOLD(hold)
   );
   sdm_sens_model sdm_sens_model_inst (
      .i_clk(clk), .i_req(sns_req), .i_wr(sns_wr), .i_sel(sns_sel),
      .i_wdata(sns_wdata), .i_fail(fail), .i_mute(mute), .i_slow(slow),
      .o_done(sns_done), .o_err(sns_err), .o_rdata(sns_rdata)
   );

   // Clock and sensor access counter
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      req_q <= sns_req;
      if (sns_req && !req_q) rises <= rises + 1;
      if (hold !== sns_req) hold_bad <= hold_bad + 1;
   end

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One frame in, one answer out, with a stall before taking it
   task automatic xfer(input logic [10:0] id, input logic [63:0] f,
         output logic [63:0] r, output logic s, input int lim, input logic must);
      int n;
      rx_id = id;
      rx_data = f;
      rx_valid = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (rx_ready !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time,
            rx_ready, 1'b1);
         end_sim;
      end
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data = ~f;
      n = 0;
      while (tx_valid !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      s = (tx_valid === 1'b1);
      r = tx_data;
      if (s) begin
         chk({53'h0, tx_id}, 64'h583);
         @(posedge clk);
         #1;
         tx_ready = 1'b1;
         @(posedge clk);
         #1;
         tx_ready = 1'b0;
      end else if (must) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time,
            1'b0, 1'b1);
         end_sim;
      end
   endtask

   task automatic run(input logic [7:0] c, input logic [15:0] x,
         input logic [7:0] b, input logic [31:0] v, input logic [63:0] e);
      logic [63:0] r;
      logic s;
      xfer(11'h603, {v, b, x, c}, r, s, 1000, 1'b1);
      chk(r, e);
   endtask

   // Main sequence
   initial begin
      logic [63:0] r;
      logic s;
      int base;
      rst = 1'b1;
      {rx_valid, tx_ready, ev, fail, mute, slow} = 6'h00;
      rx_id = 11'h000;
      rx_data = 64'h0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({60'h0, rx_ready, tx_valid, sns_req, hold}, 64'h8);
      $display("Reset test done");
      foreach (rows[i]) begin
         run(rows[i].cmd, rows[i].idx, rows[i].sub, rows[i].val,
            {rows[i].eval, rows[i].sub, rows[i].idx, rows[i].ecmd});
         $display("Row %0d done", i);
      end
      base = rises;
      run(8'h40, 16'h3590, 8'h02, 32'h0, 64'h00000101_02359043);
      run(8'h40, 16'h3590, 8'h02, 32'h0, 64'h00000101_02359043);
      chk(64'(rises - base), 64'h1);
      $display("Cache test done");
      ev = 1'b1;
      @(posedge clk);
      #1;
      ev = 1'b0;
      base = rises;
      run(8'h40, 16'h3590, 8'h02, 32'h0, 64'h00000101_02359043);
      chk(64'(rises - base), 64'h1);
      $display("Sensor event test done");
      fail = 1'b1;
      run(8'h2b, 16'h3590, 8'h03, 32'h1, 64'h06060000_03359080);
      fail = 1'b0;
      mute = 1'b1;
      run(8'h40, 16'h3590, 8'h04, 32'h0, 64'h06060000_04359080);
      mute = 1'b0;
      slow = 1'b1;
      run(8'h40, 16'h3590, 8'h05, 32'h0, 64'h00000104_05359043);
      slow = 1'b0;
      $display("Fault test done");
      // Reset in mid-run relocks and drops the cache
      run(8'h23, 16'h359f, 8'h01, 32'h6b636c75, 64'h00000000_01359f60);
      rst = 1'b1;
      @(posedge clk);
      #1;
      rst = 1'b0;
      base = rises;
      run(8'h23, 16'h3591, 8'h01, 32'h9, 64'h08000022_01359180);
      run(8'h40, 16'h3590, 8'h01, 32'h0, 64'h00000007_01359043);
      chk(64'(rises - base), 64'h1);
      $display("Mid-run reset test done");
      xfer(11'h601, 64'h00000000_00359040, r, s, 30, 1'b0);
      chk({63'h0, s}, 64'h0);
      run(8'h40, 16'h3590, 8'h00, 32'h0, 64'h0000000e_00359043);
      $display("Foreign node test done");
      chk(64'(hold_bad), 64'h0);
      end_sim;
   end
endmodule
